// ===== include/ilc_pkg.sv
// Shared constants and types of the in-band loop code unit
package ilc_pkg;

    // ************************************************************
    // Register offsets on the 8-bit host port
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL  = 8'hb6;
    localparam logic [7:0] ADDR_TX_HI = 8'hb7;
    localparam logic [7:0] ADDR_TX_LO = 8'hb8;
    localparam logic [7:0] ADDR_UP_HI = 8'hb9;
    localparam logic [7:0] ADDR_UP_LO = 8'hba;
    localparam logic [7:0] ADDR_DN_HI = 8'hbb;
    localparam logic [7:0] ADDR_DN_LO = 8'hbc;
    localparam logic [7:0] ADDR_SP_CT = 8'hbd;
    localparam logic [7:0] ADDR_SP_HI = 8'hbe;
    localparam logic [7:0] ADDR_SP_LO = 8'hbf;

    // ************************************************************
    // Reset values and field layout
    // ************************************************************
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam int         TX_LEN_LSB  = 6;
    localparam int         UP_LEN_LSB  = 3;
    localparam int         DN_LEN_LSB  = 0;
    localparam logic [7:0] SP_CT_MASK  = 8'h07;
    localparam int         STAT_UP_BIT = 5;
    localparam int         STAT_DN_BIT = 6;
    localparam int         STAT_SP_BIT = 7;
    localparam logic [2:0] RX_LEN_LONG = 3'h7;

    typedef enum logic [1:0] {
        TX_LEN5  = 2'b00,
        TX_LEN6  = 2'b01,
        TX_LEN7  = 2'b10,
        TX_LEN16 = 2'b11
    } ilc_tx_len_e;

    // ************************************************************
    // Timing and error tolerance
    // ************************************************************
    localparam int INTEG_MS   = 36;
    localparam int CLK_KHZ    = 125000;
    localparam int INTEG_CYC  = INTEG_MS * CLK_KHZ;
    localparam int ERR_SHIFT  = 6;
    localparam int ERR_SLACK  = 8;

endpackage : ilc_pkg

// ===== design/ilc_gen.sv
// Transmit repeating code generator
module ilc_gen (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control
    input  wire logic        active,
    input  wire logic [1:0]  len_sel,
    input  wire logic [15:0] code,
    input  wire logic        fbit_insert,
    // Bit stream
    input  wire logic        bit_en,
    input  wire logic        fbit_pos,
    input  wire logic        fbit_val,
    input  wire logic        data_in,
    output logic             data_out
);

    typedef struct packed {
        logic [3:0] phase;
        logic       out;
    } ilc_gen_s;

    ilc_gen_s   s_r;
    ilc_gen_s   s_nxt;
    logic [3:0] last;

    always_comb begin
        case (len_sel)
            ilc_pkg::TX_LEN5: last = 4'h4; // [R02]
            ilc_pkg::TX_LEN6: last = 4'h5; // [R02]
            ilc_pkg::TX_LEN7: last = 4'h6; // [R02] [R07]
            default:          last = 4'hf; // [R02]
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        if (!active) begin
            s_nxt.phase = 4'h0;
        end
        if (bit_en) begin
            if (fbit_pos && fbit_insert) begin
                s_nxt.out = fbit_val; // [R05]
            end else if (active) begin
                s_nxt.out = code[4'hf - s_r.phase]; // [R06] [R04]
            end else begin
                s_nxt.out = data_in; // [R04]
            end
            if (active) begin
                // Wrap without a gap; also recovers after a length change
                s_nxt.phase = (s_r.phase >= last) ? 4'h0
                                                  : s_r.phase + 4'h1; // [R20]
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign data_out = s_r.out;

    default clocking gcb @(posedge clk); endclocking
    default disable iff (rst);

    gen_wrap_a: assert property ( // [R20]
        active && bit_en && s_r.phase >= last |=> s_r.phase == 4'h0)
        else $error("generator did not restart at first code bit");

    gen_first_a: assert property ( // [R06]
        active && bit_en && s_r.phase == 4'h0 && !(fbit_pos && fbit_insert)
        |=> data_out == $past(code[15]))
        else $error("first code bit is not the top bit");

endmodule : ilc_gen

// ===== design/ilc_det.sv
// Receive repeating code detector with integration window
module ilc_det #(
    parameter int INTEG_CYC = ilc_pkg::INTEG_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control
    input  wire logic        t1_mode,
    input  wire logic        restart,
    input  wire logic [2:0]  len_sel,
    input  wire logic [15:0] code,
    // Bit stream
    input  wire logic        bit_en,
    input  wire logic        fbit_pos,
    input  wire logic        data_in,
    // Result
    output logic             detected
);

    localparam int            TW       = $clog2(INTEG_CYC + 1);
    localparam logic [TW-1:0] WIN_LAST = TW'(INTEG_CYC - 1);
    localparam logic [TW-1:0] SLACK    = TW'(ilc_pkg::ERR_SLACK);

    typedef enum logic [0:0] {
        ST_HUNT = 1'b0,
        ST_LOCK = 1'b1
    } ilc_det_state_e;

    typedef struct packed {
        ilc_det_state_e st;
        logic [15:0]    hist;
        logic [3:0]     phase;
        logic [TW-1:0]  timer;
        logic [TW-1:0]  bits;
        logic [TW-1:0]  errs;
        logic           det;
        logic           clean;
        logic [5:0]     skip;
    } ilc_det_s;

    ilc_det_s    s_r;
    ilc_det_s    s_nxt;
    logic [4:0]  len;
    logic [3:0]  last;
    logic [15:0] mask;
    logic [15:0] want;
    logic [15:0] shifted;
    logic        match;

    always_comb begin
        // Length 1..7 uses the first register only; 8/16 uses both
        len     = (len_sel == ilc_pkg::RX_LEN_LONG) ? 5'h10
                                                    : {2'b00, len_sel} + 5'h01;
        last    = 4'(len - 5'h01);
        mask    = 16'hffff >> (5'h10 - len); // [R11] [R12]
        want    = code >> (5'h10 - len); // [R10]
        shifted = {s_r.hist[14:0], data_in};
        match   = ((shifted ^ want) & mask) == 16'h0000;
    end

    always_comb begin
        s_nxt = s_r;
        if (s_r.timer == WIN_LAST) begin
            // Only a lock that spans a whole window counts
            s_nxt.det   = (s_r.st == ST_LOCK) && s_r.clean; // [R16] [R19]
            s_nxt.clean = (s_r.st == ST_LOCK);
            s_nxt.timer = '0;
            s_nxt.bits  = '0;
            s_nxt.errs  = '0;
        end else begin
            s_nxt.timer = s_r.timer + 1'b1;
        end
        if (bit_en) begin
            s_nxt.hist = shifted;
            if (s_r.st == ST_HUNT) begin
                if (match) begin
                    s_nxt.st    = ST_LOCK; // [R13]
                    s_nxt.phase = 4'h0;
                    s_nxt.bits  = '0;
                    s_nxt.errs  = '0;
                    s_nxt.skip  = 6'h00;
                end
            end else begin
                s_nxt.phase = (s_r.phase >= last) ? 4'h0
                                                  : s_r.phase + 4'h1;
                // Inserted and overwritten framing slip the phase apart;
                // stop judging until the whole code is seen again
                if (fbit_pos) begin
                    s_nxt.skip = {len, 1'b0}; // [R14]
                end else if (s_r.skip != 6'h00) begin
                    s_nxt.skip = s_r.skip - 6'h01;
                    // Framing bit must have left the compared bits
                    if (match && s_r.skip <= {1'b0, len} + 6'h01) begin
                        s_nxt.phase = 4'h0; // [R14]
                        s_nxt.skip  = 6'h00;
                    end
                end else begin
                    s_nxt.bits = s_nxt.bits + 1'b1;
                    if (data_in != code[4'hf - s_r.phase]) begin
                        s_nxt.errs = s_nxt.errs + 1'b1; // [R13]
                    end
                end
                if (s_r.errs > (s_r.bits >> ilc_pkg::ERR_SHIFT) + SLACK) begin
                    s_nxt.st    = ST_HUNT; // [R13]
                    s_nxt.clean = 1'b0;
                end
            end
        end
        if (restart || !t1_mode) begin
            s_nxt.st    = ST_HUNT; // [R15]
            s_nxt.clean = 1'b0;
            s_nxt.skip  = 6'h00;
            s_nxt.phase = 4'h0;
            s_nxt.timer = '0;
            s_nxt.bits  = '0;
            s_nxt.errs  = '0;
        end
        if (!t1_mode) begin
            s_nxt.det = 1'b0; // [R01]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign detected = s_r.det;

    default clocking dcb @(posedge clk); endclocking
    default disable iff (rst);

    det_restart_a: assert property ( // [R15]
        restart |=> s_r.st == ST_HUNT && s_r.timer == '0)
        else $error("write did not restart integration");

    det_rise_a: assert property ( // [R16]
        $rose(detected) |-> $past(s_r.timer) == WIN_LAST)
        else $error("detect set outside window end");

    det_fall_a: assert property ( // [R19]
        $fell(detected) |-> $past(s_r.timer) == WIN_LAST || !$past(t1_mode))
        else $error("detect cleared outside window end");

    det_t1_a: assert property ( // [R01]
        !t1_mode |=> !detected && s_r.st == ST_HUNT)
        else $error("detector active outside T1 mode");

endmodule : ilc_det

// ===== design/ilc_top.sv
// In-band loop code unit: host registers, generator and detectors

// Function
// [R01] Generator and all detectors work only in T1 mode.
// [R02] Control bits 7:6 pick transmit length 5, 6/3, 7 or 16/8/4/2/1.
// [R03] Software fills both transmit registers for 1/2/4/8/16-bit codes.
// [R04] Code repeats while loop enable is set; otherwise normal data passes.
// [R05] Framing bit overwrites code once per frame when insertion is on.
// [R06] First transmit register bit 7 goes out first; low bits ignored.
// [R07] Second transmit register is the low byte, used only for length 16.
// [R08] Three independent detectors: loop-up, loop-down and spare.
// [R09] Up length bits 5:3, down bits 2:0; 0-6 mean 1-7, 7 means 8/16.
// [R10] Length 16 joins both receive registers; 8-bit codes written twice.
// [R11] First receive register bit 7 is first code bit; unused bits ignored.
// [R12] Second receive register ignored for lengths one to seven.
// [R13] Detection works framed or unframed and tolerates one error per 100.
// [R14] Inserted or overwritten framing positions are both accepted.
// [R15] Writing a detector's first code register restarts its integration.
// [R16] Status bits 5, 6, 7 set after a full integration period.
// [R17] Software should poll status 50 to 1000 ms over five seconds.
// [R18] Spare length field uses the same one-to-sixteen encoding.
// [R19] Status clears after a full period without the code; not latched.
// [R20] Code shifts out top bit first and repeats without gaps.
module ilc_top #(
    parameter int INTEG_CYC = ilc_pkg::INTEG_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Host register port
    input  wire logic [7:0] cpu_addr,
    input  wire logic [7:0] cpu_wdata,
    input  wire logic       cpu_wr,
    output logic      [7:0] cpu_rdata,
    // Mode and framer control
    input  wire logic       t1_mode,
    input  wire logic       tx_loop_code_enable,
    input  wire logic       tx_fbit_insert,
    // Transmit stream
    input  wire logic       tx_bit_en,
    input  wire logic       tx_fbit_pos,
    input  wire logic       tx_fbit_val,
    input  wire logic       tx_data_in,
    output logic            tx_data_out,
    // Receive stream
    input  wire logic       rx_bit_en,
    input  wire logic       rx_fbit_pos,
    input  wire logic       rx_data_in,
    // Status
    output logic      [7:0] status_reg_three
);

    // ************************************************************
    // Register state
    // ************************************************************

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] tx_hi;
        logic [7:0] tx_lo;
        logic [7:0] up_hi;
        logic [7:0] up_lo;
        logic [7:0] dn_hi;
        logic [7:0] dn_lo;
        logic [7:0] sp_ct;
        logic [7:0] sp_hi;
        logic [7:0] sp_lo;
        logic [7:0] rdata;
    } ilc_regs_s;

    ilc_regs_s  s_r;
    ilc_regs_s  s_nxt;

    logic       up_restart;
    logic       dn_restart;
    logic       sp_restart;
    logic       tx_active;
    logic [1:0] tx_len_sel;
    logic [2:0] up_len_sel;
    logic [2:0] dn_len_sel;
    logic [2:0] sp_len_sel;
    logic       up_code_detected;
    logic       down_code_detected;
    logic       spare_code_detected;

    // ************************************************************
    // Host writes and read-back
    // ************************************************************

    always_comb begin
        s_nxt = s_r;
        if (cpu_wr) begin
            case (cpu_addr)
                ilc_pkg::ADDR_CTRL: begin
                    s_nxt.ctrl = cpu_wdata; // [R02] [R09]
                end
                ilc_pkg::ADDR_TX_HI: begin
                    s_nxt.tx_hi = cpu_wdata;
                end
                ilc_pkg::ADDR_TX_LO: begin
                    s_nxt.tx_lo = cpu_wdata;
                end
                ilc_pkg::ADDR_UP_HI: begin
                    s_nxt.up_hi = cpu_wdata;
                end
                ilc_pkg::ADDR_UP_LO: begin
                    s_nxt.up_lo = cpu_wdata;
                end
                ilc_pkg::ADDR_DN_HI: begin
                    s_nxt.dn_hi = cpu_wdata;
                end
                ilc_pkg::ADDR_DN_LO: begin
                    s_nxt.dn_lo = cpu_wdata;
                end
                ilc_pkg::ADDR_SP_CT: begin
                    // Only the length field is kept
                    s_nxt.sp_ct = cpu_wdata & ilc_pkg::SP_CT_MASK; // [R18]
                end
                ilc_pkg::ADDR_SP_HI: begin
                    s_nxt.sp_hi = cpu_wdata;
                end
                ilc_pkg::ADDR_SP_LO: begin
                    s_nxt.sp_lo = cpu_wdata;
                end
                default: begin
                    s_nxt.ctrl = s_r.ctrl;
                end
            endcase
        end

        // Read data follows the address one cycle later
        case (cpu_addr)
            ilc_pkg::ADDR_CTRL:  s_nxt.rdata = s_r.ctrl;
            ilc_pkg::ADDR_TX_HI: s_nxt.rdata = s_r.tx_hi;
            ilc_pkg::ADDR_TX_LO: s_nxt.rdata = s_r.tx_lo;
            ilc_pkg::ADDR_UP_HI: s_nxt.rdata = s_r.up_hi;
            ilc_pkg::ADDR_UP_LO: s_nxt.rdata = s_r.up_lo;
            ilc_pkg::ADDR_DN_HI: s_nxt.rdata = s_r.dn_hi;
            ilc_pkg::ADDR_DN_LO: s_nxt.rdata = s_r.dn_lo;
            ilc_pkg::ADDR_SP_CT: s_nxt.rdata = s_r.sp_ct;
            ilc_pkg::ADDR_SP_HI: s_nxt.rdata = s_r.sp_hi;
            ilc_pkg::ADDR_SP_LO: s_nxt.rdata = s_r.sp_lo;
            default:             s_nxt.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r.ctrl  <= ilc_pkg::REG_RESET;
            s_r.tx_hi <= ilc_pkg::REG_RESET;
            s_r.tx_lo <= ilc_pkg::REG_RESET;
            s_r.up_hi <= ilc_pkg::REG_RESET;
            s_r.up_lo <= ilc_pkg::REG_RESET;
            s_r.dn_hi <= ilc_pkg::REG_RESET;
            s_r.dn_lo <= ilc_pkg::REG_RESET;
            s_r.sp_ct <= ilc_pkg::REG_RESET;
            s_r.sp_hi <= ilc_pkg::REG_RESET;
            s_r.sp_lo <= ilc_pkg::REG_RESET;
            s_r.rdata <= 8'h00;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cpu_rdata = s_r.rdata;

    // ************************************************************
    // Field decode and restart strobes
    // ************************************************************

    assign tx_len_sel = s_r.ctrl[ilc_pkg::TX_LEN_LSB +: 2]; // [R02]
    assign up_len_sel = s_r.ctrl[ilc_pkg::UP_LEN_LSB +: 3]; // [R09]
    assign dn_len_sel = s_r.ctrl[ilc_pkg::DN_LEN_LSB +: 3]; // [R09]
    assign sp_len_sel = s_r.sp_ct[2:0]; // [R18]

    assign up_restart = cpu_wr && cpu_addr == ilc_pkg::ADDR_UP_HI; // [R15]
    assign dn_restart = cpu_wr && cpu_addr == ilc_pkg::ADDR_DN_HI; // [R15]
    assign sp_restart = cpu_wr && cpu_addr == ilc_pkg::ADDR_SP_HI; // [R15]

    // Generator runs only in T1 mode with the loop enable set
    assign tx_active = t1_mode && tx_loop_code_enable; // [R01] [R04]

    // ************************************************************
    // Transmit generator
    // ************************************************************

    ilc_gen u_gen (
        .clk         (clk),
        .rst         (rst),
        .active      (tx_active),
        .len_sel     (tx_len_sel),
        .code        ({s_r.tx_hi, s_r.tx_lo}), // [R07]
        .fbit_insert (tx_fbit_insert),
        .bit_en      (tx_bit_en),
        .fbit_pos    (tx_fbit_pos),
        .fbit_val    (tx_fbit_val),
        .data_in     (tx_data_in),
        .data_out    (tx_data_out)
    );

    // ************************************************************
    // Receive detectors
    // ************************************************************

    ilc_det #(
        .INTEG_CYC (INTEG_CYC)
    ) u_det_up ( // [R08]
        .clk      (clk),
        .rst      (rst),
        .t1_mode  (t1_mode),
        .restart  (up_restart),
        .len_sel  (up_len_sel),
        .code     ({s_r.up_hi, s_r.up_lo}), // [R10]
        .bit_en   (rx_bit_en),
        .fbit_pos (rx_fbit_pos),
        .data_in  (rx_data_in),
        .detected (up_code_detected)
    );

    ilc_det #(
        .INTEG_CYC (INTEG_CYC)
    ) u_det_dn ( // [R08]
        .clk      (clk),
        .rst      (rst),
        .t1_mode  (t1_mode),
        .restart  (dn_restart),
        .len_sel  (dn_len_sel),
        .code     ({s_r.dn_hi, s_r.dn_lo}), // [R10]
        .bit_en   (rx_bit_en),
        .fbit_pos (rx_fbit_pos),
        .data_in  (rx_data_in),
        .detected (down_code_detected)
    );

    ilc_det #(
        .INTEG_CYC (INTEG_CYC)
    ) u_det_sp ( // [R08]
        .clk      (clk),
        .rst      (rst),
        .t1_mode  (t1_mode),
        .restart  (sp_restart),
        .len_sel  (sp_len_sel),
        .code     ({s_r.sp_hi, s_r.sp_lo}), // [R10]
        .bit_en   (rx_bit_en),
        .fbit_pos (rx_fbit_pos),
        .data_in  (rx_data_in),
        .detected (spare_code_detected)
    );

    // ************************************************************
    // Status
    // ************************************************************

    always_comb begin
        status_reg_three = 8'h00;
        status_reg_three[ilc_pkg::STAT_UP_BIT] = up_code_detected; // [R16]
        status_reg_three[ilc_pkg::STAT_DN_BIT] = down_code_detected; // [R16]
        status_reg_three[ilc_pkg::STAT_SP_BIT] = spare_code_detected; // [R16]
    end

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking tcb @(posedge clk); endclocking
    default disable iff (rst);

    sequence ctrl_write_s;
        cpu_wr && cpu_addr == ilc_pkg::ADDR_CTRL;
    endsequence

    sequence ctrl_read_s;
        !cpu_wr && cpu_addr == ilc_pkg::ADDR_CTRL;
    endsequence

    sequence spct_write_s;
        cpu_wr && cpu_addr == ilc_pkg::ADDR_SP_CT;
    endsequence

    sequence spct_read_s;
        !cpu_wr && cpu_addr == ilc_pkg::ADDR_SP_CT;
    endsequence

    ctrl_readback_a: assert property ( // [R02]
        ctrl_write_s ##1 ctrl_read_s |=> cpu_rdata == $past(cpu_wdata, 2))
        else $error("control register read-back mismatch");

    spare_field_a: assert property ( // [R18]
        spct_write_s ##1 spct_read_s
        |=> cpu_rdata == ($past(cpu_wdata, 2) & ilc_pkg::SP_CT_MASK))
        else $error("spare control unused bits not zero");

    tx_pass_a: assert property ( // [R04]
        tx_bit_en && !tx_active && !(tx_fbit_pos && tx_fbit_insert)
        |=> tx_data_out == $past(tx_data_in))
        else $error("normal data not passed while loop code off");

    tx_fbit_a: assert property ( // [R05]
        tx_bit_en && tx_fbit_pos && tx_fbit_insert
        |=> tx_data_out == $past(tx_fbit_val))
        else $error("framing bit not inserted");

    tx_hold_a: assert property ( // [R20]
        !tx_bit_en |=> $stable(tx_data_out))
        else $error("transmit bit changed without a bit slot");

    stat_zero_a: assert property ( // [R16]
        status_reg_three[4:0] == 5'h00)
        else $error("status holds bits outside 7:5");

    stat_t1_a: assert property ( // [R01]
        !t1_mode ##1 !t1_mode |-> status_reg_three == 8'h00)
        else $error("loop code status set outside T1 mode");

    stat_restart_a: assert property ( // [R15]
        up_restart ##1 !up_restart [*2]
        |-> $stable(up_code_detected) || $past(!t1_mode))
        else $error("up detector status moved right after restart");

endmodule : ilc_top

// ===== testbench/ilc_far_end.sv
// Far-end T1 equipment sending a repeating code on the receive line
module ilc_far_end (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Pattern
    input  wire logic [15:0] code,
    input  wire logic [4:0]  len,
    // Line
    output logic             bit_en,
    output logic             fbit_pos,
    output logic             data
);
    timeunit 1ns;
    timeprecision 1ps;
    int div;
    int pos;
    int ph;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div      <= 0;
            pos      <= 0;
            ph       <= 0;
            bit_en   <= 1'b0;
            fbit_pos <= 1'b0;
            data     <= 1'b0;
        end else begin
            div    <= (div + 1) % 4;
            bit_en <= (div == 0);
            if (div == 0) begin
                pos      <= (pos + 1) % 193;
                fbit_pos <= (pos == 0);
                // Framed stream with inserted framing bits
                data     <= (pos == 0) ? 1'b1 : code[15 - (ph % len)];
                if (pos != 0)
                    ph <= (ph + 1) % len;
            end else begin
                // Line value is meaningless between bit slots
                data <= ~data;
            end
        end
    end
endmodule : ilc_far_end

// ===== testbench/tb_inband_loop_code_gen_detect.sv
// Self-checking bench for the in-band loop code unit
module tb_inband_loop_code_gen_detect;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, cpu_wr, t1_mode, tx_loop_code_enable;
    logic        tx_fbit_insert, tx_bit_en, tx_fbit_pos, tx_fbit_val;
    logic        tx_data_in, tx_data_out, rx_bit_en, rx_fbit_pos, rx_data_in;
    logic [7:0]  cpu_addr, cpu_wdata, cpu_rdata, status_reg_three;
    logic [7:0]  mdl [256];
    logic [15:0] txc, far_code;
    logic [4:0]  far_len;
    int          errors = 0;
    int          compares = 0;
    int          cycles = 0;
    int          ph, len;

    ilc_top #(.INTEG_CYC(200)) uut (.clk, .rst, .cpu_addr, .cpu_wdata,
        .cpu_wr, .cpu_rdata, .t1_mode, .tx_loop_code_enable, .tx_fbit_insert,
        .tx_bit_en, .tx_fbit_pos, .tx_fbit_val, .tx_data_in, .tx_data_out,
        .rx_bit_en, .rx_fbit_pos, .rx_data_in, .status_reg_three);
    ilc_far_end far (.clk, .rst, .code(far_code), .len(far_len),
        .bit_en(rx_bit_en), .fbit_pos(rx_fbit_pos), .data(rx_data_in));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu_addr  = a;
        cpu_wdata = d;
        cpu_wr    = 1'b1;
        if (a >= 8'hb6 && a <= 8'hbf)
            mdl[a] = (a == 8'hbd) ? (d & 8'h07) : d;
        tick();
        cpu_wr = 1'b0;
        tick();
    endtask : wr

    task automatic rd(input logic [7:0] a);
        cpu_addr = a;
        tick();
        tick();
        check(cpu_rdata, mdl[a]);
    endtask : rd

    task automatic slot(input int s, input logic en, input logic t1);
        logic exp;
        tx_bit_en           = 1'b1;
        tx_fbit_pos         = (s % 193 == 0);
        tx_fbit_val         = 1'($urandom);
        tx_data_in          = 1'($urandom);
        tx_loop_code_enable = en;
        t1_mode             = t1;
        exp = (tx_fbit_pos && tx_fbit_insert) ? tx_fbit_val
            : (en && t1) ? txc[15 - ph] : tx_data_in;
        ph = (en && t1) ? (ph + 1) % len : 0;
        tick();
        check({7'h00, tx_data_out}, {7'h00, exp});
    endtask : slot

    task automatic await(input logic [7:0] exp);
        int n;
        for (n = 0; n < 2000 && status_reg_three !== exp; n++)
            tick();
        check(status_reg_three, exp);
    endtask : await

    task automatic complete_run();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            errors++;
            complete_run();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'he5b2));
        {rst, cpu_wr, t1_mode, tx_loop_code_enable, tx_fbit_insert} = 5'h12;
        {tx_bit_en, tx_fbit_pos, tx_fbit_val, tx_data_in} = 4'h0;
        {cpu_addr, cpu_wdata} = 16'h0000;
        far_code = 16'h8000;
        far_len  = 5'd5;
        foreach (mdl[i])
            mdl[i] = 8'h00;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        for (int a = 8'hb4; a < 8'hc2; a++)
            rd(8'(a));
        $display("register reset test done");
        for (int a = 8'hb4; a < 8'hc2; a++)
            wr(8'(a), 8'($urandom));
        for (int a = 8'hb4; a < 8'hc2; a++)
            rd(8'(a));
        $display("register access test done");
        for (int k = 0; k < 5; k++) begin
            len = (k == 0) ? 5 : (k == 1) ? 6 : (k == 2) ? 7 : 16;
            txc = 16'($urandom);
            wr(8'hb6, 8'((k > 3 ? 3 : k) << 6));
            wr(8'hb7, txc[15:8]);
            wr(8'hb8, txc[7:0]);
            tx_fbit_insert = k[0];
            ph = 0;
            for (int s = 0; s < 200; s++)
                slot(s, s > 2, k < 4);
            tx_bit_en = 1'b0;
            $display("transmit length %0d test done", len);
        end
        t1_mode = 1'b1;
        tx_loop_code_enable = 1'b0;
        wr(8'hb6, 8'h27);
        wr(8'hbb, 8'hf0);
        wr(8'hbc, 8'h0f);
        wr(8'hbd, 8'h02);
        wr(8'hbe, 8'hc0);
        wr(8'hbf, 8'($urandom));
        wr(8'hb9, 8'h80);
        await(8'h20);
        $display("loop-up detection test done");
        far_code = 16'hc000;
        far_len  = 5'd3;
        await(8'h80);
        $display("spare detection test done");
        far_code = 16'hf00f;
        far_len  = 5'd16;
        await(8'h40);
        $display("loop-down detection test done");
        t1_mode = 1'b0;
        tick();
        tick();
        check(status_reg_three, 8'h00);
        $display("mode test done");
        complete_run();
    end
endmodule : tb_inband_loop_code_gen_detect
